// >>> core/scic_pkg.sv
// scic_pkg: constants and types shared by the step clock input control
// assumes: included before every other design file
package scic_pkg;
   // ----------------------------------------------------------------
   // angle and resolution
   // ----------------------------------------------------------------
   localparam int ANGLE_W = 9;
   localparam logic [8:0] ANGLE_HOME = 9'h000;
   localparam logic [8:0] ANGLE_QUARTER = 9'h080;
   localparam int RES_W = 3;
   // ----------------------------------------------------------------
   // ahb-lite
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam int CTRL_OUTEN = 0;
   localparam int CTRL_DBLEDGE = 1;
   localparam int CTRL_DIR = 2;
   localparam int CTRL_RES = 4;
   localparam int CTRL_HOME = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {SCIC_CLK_MODE, SCIC_SERIAL_MODE} scic_if_t;
   typedef enum logic [1:0] {SCIC_DRIVE_OFF, SCIC_DRIVE_ON} scic_drv_t;
endpackage : scic_pkg

// >>> core/scic_step_if.sv
// scic_step_if: qualified step event between edge detector and counter
// assumes: one clock domain, clk_sys
`timescale 1ns/1ps
interface scic_step_if;
   logic stepPulse;
   modport src (output stepPulse);
   modport dst (input stepPulse);
endinterface : scic_step_if

// >>> core/scic_edge_detect.sv
// scic_edge_detect: turns step input edges into one-cycle step pulses
// assumes: step input synchronous to clk_sys
`timescale 1ns/1ps
module scic_edge_detect (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic stepIn,
   input wire logic dblEdge,
   input wire logic clkMode,
   scic_step_if.src step
);
   import scic_pkg::*;
   logic prev_q;
   logic prev_d;
   logic pulse_q;
   logic pulse_d;
   always_comb begin
      prev_d = stepIn;
      pulse_d = 1'b0;
      if (clkMode && stepIn && !prev_q) begin
         pulse_d = 1'b1; // [R2]
      end
      if (clkMode && dblEdge && !stepIn && prev_q) begin
         pulse_d = 1'b1; // [R4]
      end
      // falling edge without dblEdge gives no pulse [R3]
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         pulse_q <= pulse_d;
      end
   end
   assign step.stepPulse = pulse_q;
endmodule : scic_edge_detect

// >>> core/scic_top.sv
// scic_top: step clock input control with ahb-lite register access
// assumes: pins synchronous to clk_sys, single ahb-lite master
// How it works
// [R1] interface select low means step-clock mode, high means serial mode.
// [R2] every rising step edge advances the angle by one step.
// [R3] with single-edge counting a falling step edge changes nothing.
// [R4] with double-edge counting both step edges advance the angle.
// [R5] output enable low turns off all bridge outputs to high impedance.
// [R6] output enable high drives the motor outputs normally.
// [R7] the controller keeps output enable low while the supply settles.
// [R8] direction high leads phase A by a quarter, low leads phase B.
// [R9] the resolution code picks step size full to 1/128, changeable live.
// [R10] angle-home returns the angle to its initial value in step mode.
// [R11] the angle counter wraps at one electrical cycle either way.
`timescale 1ns/1ps
module scic_top (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic interfaceSelect,
   input wire logic stepIn,
   input wire logic edgeCountSelect,
   input wire logic rotationDirection,
   input wire logic [scic_pkg::RES_W-1:0] resolutionSelect,
   input wire logic angleHome,
   input wire logic outputEnable,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [scic_pkg::ANGLE_W-1:0] phaseAAngle,
   output logic [scic_pkg::ANGLE_W-1:0] phaseBAngle,
   output logic bridgeDriveEn,
   output logic serialModeActive
);
   import scic_pkg::*;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [ANGLE_W-1:0] stepSize(
      input logic [RES_W-1:0] code);
      stepSize = ANGLE_QUARTER >> code; // [R9]
   endfunction : stepSize
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] count_q, count_d;
   logic [31:0] rdata_q, rdata_d;
   logic wrPend_q, wrPend_d;
   logic rdPend_q, rdPend_d;
   logic [7:0] addr_q, addr_d;
   logic [ANGLE_W-1:0] angle_q, angle_d;
   logic drv_q, drv_d;
   logic ser_q, ser_d;
   logic [ANGLE_W-1:0] pa_q, pa_d, pb_q, pb_d;
   logic clkMode;
   logic dblEdge;
   logic dirEff;
   logic [RES_W-1:0] resEff;
   logic homeReq;
   logic enEff;
   scic_step_if stepBus ();
   assign clkMode = !interfaceSelect; // [R1]
   assign dblEdge = edgeCountSelect | ctrl_q[CTRL_DBLEDGE];
   assign dirEff = rotationDirection ^ ctrl_q[CTRL_DIR];
   assign resEff = resolutionSelect | ctrl_q[CTRL_RES +: RES_W];
   assign homeReq = angleHome | ctrl_q[CTRL_HOME];
   assign enEff = outputEnable & !ctrl_q[CTRL_OUTEN];
   scic_edge_detect uEdge (
      .clk_sys(clk_sys),
      .srst(srst),
      .stepIn(stepIn),
      .dblEdge(dblEdge),
      .clkMode(clkMode),
      .step(stepBus.src)
   );
   always_comb begin
      ctrl_d = ctrl_q;
      addr_d = addr_q;
      wrPend_d = 1'b0;
      rdPend_d = 1'b0;
      rdata_d = rdata_q;
      if (wrPend_q && addr_q == ADDR_CTRL) begin
         ctrl_d = hwdata;
      end
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
         addr_d = haddr[7:0];
         wrPend_d = hwrite;
         rdPend_d = !hwrite;
         case (haddr[7:0])
            ADDR_CTRL: rdata_d = ctrl_q;
            ADDR_STATUS: rdata_d = {21'h0, ser_q, drv_q, angle_q};
            ADDR_COUNT: rdata_d = count_q;
            default: rdata_d = 32'h0;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // angle counter and outputs
   // ----------------------------------------------------------------
   always_comb begin
      angle_d = angle_q;
      count_d = count_q;
      if (clkMode && homeReq) begin
         angle_d = ANGLE_HOME; // [R10]
      end else if (stepBus.stepPulse) begin
         count_d = count_q + 32'h1;
         if (dirEff) begin
            angle_d = angle_q + stepSize(resEff); // [R2] [R11]
         end else begin
            angle_d = angle_q - stepSize(resEff); // [R11]
         end
      end
      drv_d = enEff; // [R5] [R6]
      ser_d = !clkMode; // [R1]
      pa_d = angle_d;
      pb_d = angle_d - ANGLE_QUARTER; // [R8]
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_q <= CTRL_RESET;
         count_q <= 32'h0;
         rdata_q <= 32'h0;
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         addr_q <= 8'h00;
         angle_q <= ANGLE_HOME;
         drv_q <= 1'b0;
         ser_q <= 1'b0;
         pa_q <= ANGLE_HOME;
         pb_q <= ANGLE_HOME - ANGLE_QUARTER; // [R8]
      end else begin
         ctrl_q <= ctrl_d;
         count_q <= count_d;
         rdata_q <= rdata_d;
         wrPend_q <= wrPend_d;
         rdPend_q <= rdPend_d;
         addr_q <= addr_d;
         angle_q <= angle_d;
         drv_q <= drv_d;
         ser_q <= ser_d;
         pa_q <= pa_d;
         pb_q <= pb_d;
      end
   end
   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign phaseAAngle = pa_q;
   assign phaseBAngle = pb_q;
   assign bridgeDriveEn = drv_q;
   assign serialModeActive = ser_q;
endmodule : scic_top

// >>> sim/scic_ctrl_model.sv
// controller model: flips the step level on request
// assumes: clk_sys domain, bench paces requests
`timescale 1ns/1ps
module scic_ctrl_model (
   input wire logic clk_sys,
   input wire logic req,
   output logic stepIn
);
   initial stepIn = 1'b0;
   always @(posedge clk_sys) stepIn <= stepIn ^ req;
endmodule : scic_ctrl_model

// >>> sim/scic_top_chk.sv
// checker of scic_top pin relations
// assumes: control register kept at its reset value
`timescale 1ns/1ps
module scic_top_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic interfaceSelect,
   input wire logic stepIn,
   input wire logic edgeCountSelect,
   input wire logic angleHome,
   input wire logic outputEnable,
   input wire logic [scic_pkg::ANGLE_W-1:0] phaseAAngle,
   input wire logic [scic_pkg::ANGLE_W-1:0] phaseBAngle,
   input wire logic bridgeDriveEn,
   input wire logic serialModeActive
);
   import scic_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire logic go = !interfaceSelect && !angleHome;
   wire logic dbl = edgeCountSelect;
   AST_MODE: assert property (!$past(srst) |->
      serialModeActive == $past(interfaceSelect)) else $error("mode");
   AST_RISE: assert property ($rose(stepIn) && go |-> ##2
      phaseAAngle != $past(phaseAAngle)) else $error("rise");
   AST_FALL1: assert property ($fell(stepIn) && !dbl && go |-> ##2
      $stable(phaseAAngle)) else $error("fall single");
   AST_FALL2: assert property ($fell(stepIn) && dbl && go |-> ##2
      phaseAAngle != $past(phaseAAngle)) else $error("fall double");
   AST_OFF: assert property (!outputEnable |=> !bridgeDriveEn)
      else $error("off");
   AST_ON: assert property (outputEnable |=> bridgeDriveEn)
      else $error("on");
   AST_QUARTER: assert property (
      phaseBAngle == phaseAAngle - ANGLE_QUARTER) else $error("quarter");
   AST_HOME: assert property ((angleHome && !interfaceSelect)[*3] |->
      phaseAAngle == ANGLE_HOME) else $error("home");
endmodule : scic_top_chk
bind scic_top scic_top_chk scic_top_chk_i (.clk_sys(clk_sys), .srst(srst),
   .interfaceSelect(interfaceSelect), .stepIn(stepIn),
   .edgeCountSelect(edgeCountSelect), .angleHome(angleHome),
   .outputEnable(outputEnable), .phaseAAngle(phaseAAngle),
   .phaseBAngle(phaseBAngle), .bridgeDriveEn(bridgeDriveEn),
   .serialModeActive(serialModeActive));

// >>> sim/tb.sv
// tb: steps scic_top through the controller model, checks an angle model
// assumes: package, design, model and checker compiled first
`timescale 1ns/1ps
module tb;
   import scic_pkg::*;
   logic clk_sys, srst, ifSel, req, dbl, dir, home, oe, wr, rdy, drv, ser;
   logic stepIn;
   logic hrs;
   int nStep = 0;
   logic [2:0] res;
   logic [1:0] tr;
   logic [31:0] ad, wd, hrd, rd;
   logic [8:0] pA, pB;
   int n_fail = 0, n_compared = 0, cyc = 0, ang = 0;
   scic_ctrl_model scic_ctrl_model_i (.clk_sys(clk_sys), .req(req),
      .stepIn(stepIn));
   scic_top scic_top_i (.clk_sys(clk_sys), .srst(srst),
      .interfaceSelect(ifSel), .stepIn(stepIn), .edgeCountSelect(dbl),
      .rotationDirection(dir), .resolutionSelect(res), .angleHome(home),
      .outputEnable(oe), .hsel(1'b1), .haddr(ad), .htrans(tr),
      .hwrite(wr), .hsize(3'h2), .hwdata(wd), .hready(rdy), .hrdata(hrd),
      .hreadyout(rdy), .hresp(hrs), .phaseAAngle(pA), .phaseBAngle(pB),
      .bridgeDriveEn(drv), .serialModeActive(ser));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic bus(input logic w, input logic [7:0] a);
      tr <= HTRANS_NONSEQ;
      ad <= {24'h0, a};
      wr <= w;
      @(posedge clk_sys);
      while (!rdy) @(posedge clk_sys);
      tr <= 2'h0;
      wd <= CTRL_RESET;
      @(posedge clk_sys);
      while (!rdy) @(posedge clk_sys);
      rd = hrd;
   endtask : bus
   task automatic run(input int n);
      for (int i = 0; i < n; i++) begin
         res <= 3'($urandom);
         dir <= 1'($urandom);
         dbl <= 1'($urandom);
         @(posedge clk_sys);
         req <= 1'b1;
         @(posedge clk_sys);
         req <= 1'b0;
         repeat (3 + i % 3) @(posedge clk_sys);
         if ((stepIn || dbl) && !ifSel && !home) begin
            ang = (ang + (dir ? 1 : -1) * (128 >> res) + 512) % 512;
            nStep++;
         end
         chk(pA, ang);
         chk(pB, (ang + 384) % 512);
      end
   endtask : run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      {srst, ifSel, req, dbl, dir, home, oe, wr} = 8'h80;
      res = 3'h0;
      tr = 2'h0;
      ad = 32'h0;
      wd = 32'h0;
      void'($urandom(30));
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      oe <= 1'b1;
      run(60);
      ifSel <= 1'b1;
      run(6);
      chk(ser, 1'b1);
      bus(0, ADDR_STATUS);
      chk(rd, 32'h600 | ang);
      chk(hrs, 1'b0);
      bus(0, ADDR_COUNT);
      chk(rd, nStep);
      ifSel <= 1'b0;
      home <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ang = 0;
      run(4);
      home <= 1'b0;
      oe <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(drv, 1'b0);
      bus(1, ADDR_CTRL);
      bus(0, ADDR_CTRL);
      chk(rd, CTRL_RESET);
      bus(0, 8'h0c);
      chk(rd, 32'h0);
      oe <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(drv, 1'b1);
      finish_test();
   end
endmodule : tb
